/* File: verification/act_timing_asserts.sv */
`timescale 1ns/1ps
module act_timing_asserts (
  // Clock and reset
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  // Watched ports
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        rc_clk_tick_in,
  input wire logic        sample_start_in,
  input wire logic        conv_clock_tick_out,
  input wire logic        conv_clock_source_sel_out,
  input wire logic [4:0]  auto_sample_time_out,
  input wire logic [7:0]  conv_clock_divider_out,
  input wire logic        sampling_out,
  input wire logic        sample_done_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  logic [8:0] gap;
  logic       gap_ok;
  logic [5:0] smp_cnt;
  // Period trusted only when no write restarted the divider
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gap     <= 9'h000;
      gap_ok  <= 1'b0;
      smp_cnt <= 6'h00;
    end else begin
      gap     <= conv_clock_tick_out ? 9'h001 : gap + 9'h001;
      gap_ok  <= (conv_clock_tick_out | gap_ok) & ~s_axi_bvalid_out & ~conv_clock_source_sel_out;
      smp_cnt <= sampling_out ? smp_cnt + {5'h00, conv_clock_tick_out} : 6'h00;
    end
  end
  sequence s_idle_start;
    sample_start_in && !sampling_out;
  endsequence
  sequence s_div0_quiet;
    (!conv_clock_source_sel_out && conv_clock_divider_out == 8'h00 && !s_axi_bvalid_out)[*4];
  endsequence
  AST_SRC_RC: assert property (conv_clock_source_sel_out ##1 conv_clock_source_sel_out |->
    conv_clock_tick_out == $past(rc_clk_tick_in) || s_axi_bvalid_out) else $error("rc tick lost");
  // Gap still counts the old period in the cycle the divider changes
  AST_DIV_PERIOD: assert property (gap_ok && conv_clock_tick_out &&
    $stable(conv_clock_divider_out) |-> gap == {1'b0, conv_clock_divider_out} + 9'h001)
    else $error("tick period wrong");
  AST_DIV_LATE: assert property (gap_ok && $stable(conv_clock_divider_out) |->
    gap <= {1'b0, conv_clock_divider_out} + 9'h001) else $error("tick missing");
  AST_DIV0_EACH: assert property (s_div0_quiet |-> conv_clock_tick_out)
    else $error("divider zero not every cycle");
  AST_SMP_OPEN: assert property (s_idle_start ##0 auto_sample_time_out != 5'h00 |=>
    sampling_out) else $error("window not opened");
  AST_SMP_LEN: assert property ($fell(sampling_out) |->
    sample_done_out && smp_cnt == {1'b0, auto_sample_time_out}) else $error("window length");
  AST_SMP_ZERO: assert property (s_idle_start ##0 auto_sample_time_out == 5'h00 |=>
    sample_done_out && !sampling_out) else $error("zero window");
  AST_RSVD_ZERO: assert property (s_axi_rvalid_out |->
    s_axi_rdata_out[31:16] == 16'h0000 && s_axi_rdata_out[14:13] == 2'b00) else $error("unused");
endmodule : act_timing_asserts

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import act_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
  logic        s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out, sample_start_in;
  logic        rc_clk_tick_in = 1'b0;
  logic        conv_clock_tick_out, conv_clock_source_sel_out, sampling_out, sample_done_out;
  logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d;
  logic [3:0]  s_axi_wstrb_in, s;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic [4:0]  auto_sample_time_out;
  logic [7:0]  conv_clock_divider_out;
  logic [15:0] ctrl;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  logic [4:0]  exp_d[$];
  int          n_tick = 0;
  logic [31:0] tbl[3] = '{32'hffff_ffff, 32'h0000_0001, 32'h0000_1f00};
  int          seed = 32'h82f7, n_mismatch = 0, checked = 0, cyc = 0;
  act_timing u_dut (.*);
  always #10 ref_clk_in = ~ref_clk_in;
  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_rd
  task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_wr
  task automatic cmp_smp(input logic [4:0] e, input logic [4:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_smp
  task automatic close_out;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] st);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge ref_clk_in);
    exp_b.push_back((a == ACT_CTRL_OFFSET || a == ACT_STAT_OFFSET) ? ACT_RESP_OKAY
                                                                    : ACT_RESP_SLVERR);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= v;
    s_axi_wstrb_in <= st;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
    while (!(aw && w)) begin
      @(posedge ref_clk_in);
      if (!aw && s_axi_awready_out) begin
        aw = 1'b1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (!w && s_axi_wready_out) begin
        w = 1'b1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    do @(posedge ref_clk_in); while (!s_axi_bvalid_out);
    s_axi_bready_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge ref_clk_in);
    exp_r.push_back(e);
    s_axi_araddr_in <= a;
    {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
    do @(posedge ref_clk_in); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge ref_clk_in); while (!s_axi_rvalid_out);
    s_axi_rready_in <= 1'b0;
  endtask : rd
  // Scoreboard and hang guard
  always @(posedge ref_clk_in) begin
    rc_clk_tick_in <= ($random(seed) % 3) == 0;
    cyc++;
    if (s_axi_rvalid_out && s_axi_rready_in) begin
      cmp_rd(exp_r.pop_front(), {s_axi_rresp_out, s_axi_rdata_out});
    end
    if (s_axi_bvalid_out && s_axi_bready_in) begin
      cmp_wr(exp_b.pop_front(), s_axi_bresp_out);
    end
    // Conversion periods seen inside the sampling window
    if (sampling_out && conv_clock_tick_out) n_tick++;
    if (sample_done_out) begin
      cmp_smp(exp_d.pop_front(), 5'(n_tick));
      n_tick = 0;
    end
    if (cyc == 95000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in,
     s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in, sample_start_in} <= '0;
    ctrl = ACT_CTRL_RESET;
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    rd(ACT_CTRL_OFFSET, {ACT_RESP_OKAY, 16'h0000, ctrl});
    for (int i = 0; i < 10; i++) begin
      d = (i < 3) ? tbl[i] : $random(seed);
      s = (i < 3) ? 4'hf : 4'($random(seed));
      if (s[0]) ctrl[7:0] = d[7:0];
      if (s[1]) ctrl[15:8] = d[15:8] & ACT_CTRL_WMASK[15:8];
      wr(ACT_CTRL_OFFSET, d, s);
      rd(ACT_CTRL_OFFSET, {ACT_RESP_OKAY, 16'h0000, ctrl});
      exp_d.push_back(ctrl[12:8]);
      sample_start_in <= 1'b1;
      @(posedge ref_clk_in);
      sample_start_in <= 1'b0;
      repeat (9000) begin
        @(posedge ref_clk_in);
        if (sample_done_out) break;
      end
    end
    wr(ACT_STAT_OFFSET, 32'hffff_ffff, 4'hf);
    wr(12'h008, 32'hffff_ffff, 4'hf);
    rd(12'h00c, {ACT_RESP_SLVERR, 32'h0000_0000});
    rd(ACT_CTRL_OFFSET, {ACT_RESP_OKAY, 16'h0000, ctrl});
    // Idle status: source bit only, no window, count run down
    rd(ACT_STAT_OFFSET, {ACT_RESP_OKAY, 16'h0000, 15'h0000, ctrl[15]});
    repeat (4) @(posedge ref_clk_in);
    cmp_smp(5'(exp_d.size()), 5'h00);
    close_out();
  end
endmodule : testbench
bind act_timing act_timing_asserts u_chk (.*);

/* File: verilog/act_pkg.sv */
// Summary of operation
// RL1: Source select bit 15 set picks internal RC clock; clear picks system clock.
// RL2: Five-bit sample time field counts sampling in conversion clock periods; ones gives 31.
// RL3: Divider codes from all ones downward are reserved; no period is promised for them.
// RL4: System-derived conversion period equals instruction cycle times divider value plus one.
// RL5: Divider one gives two instruction cycles; divider zero gives one.
// RL6: Bits 14 and 13 ignore writes and always read back zero.
package act_pkg;

  localparam int unsigned ACT_ADDR_W      = 12;
  localparam int unsigned ACT_DATA_W      = 32;
  localparam int unsigned ACT_REG_W       = 16;
  localparam int unsigned ACT_DIV_W       = 8;
  localparam int unsigned ACT_SAMC_W      = 5;

  // Register byte offsets
  localparam logic [11:0] ACT_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] ACT_STAT_OFFSET = 12'h004;

  // Control register layout
  localparam int unsigned ACT_SRC_BIT     = 15;
  localparam int unsigned ACT_SAMC_LSB    = 8;
  localparam int unsigned ACT_DIV_LSB     = 0;
  localparam logic [15:0] ACT_CTRL_WMASK  = 16'h9fff;
  localparam logic [15:0] ACT_CTRL_RESET  = 16'h0000;

  // Status register layout
  localparam int unsigned ACT_STAT_SRC_BIT  = 0;
  localparam int unsigned ACT_STAT_BUSY_BIT = 1;
  localparam int unsigned ACT_STAT_CNT_LSB  = 8;

  // Write strobe lanes
  localparam int unsigned ACT_LANE_LO     = 0;
  localparam int unsigned ACT_LANE_HI     = 1;
  localparam logic [15:0] ACT_LANE_LO_MSK = 16'h00ff;
  localparam logic [15:0] ACT_LANE_HI_MSK = 16'hff00;

  // Response codes
  localparam logic [1:0]  ACT_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  ACT_RESP_SLVERR = 2'h2;

  localparam logic [31:0] ACT_ZERO_WORD   = 32'h0000_0000;

endpackage : act_pkg

/* File: verilog/act_tick_div.sv */
`timescale 1ns/1ps
module act_tick_div #(
  parameter int unsigned DIV_W = 8
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  // Control
  input  wire logic [DIV_W-1:0] div_in,
  input  wire logic             restart_in,
  // Tick
  output logic                  tick_out
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } act_div_state_t;

  act_div_state_t state;
  act_div_state_t next_state;

  // One tick every div_in plus one cycles; reserved codes just divide
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (restart_in) begin
      next_state.cnt = '0;
    end else if (state.cnt >= div_in) begin
      next_state.cnt  = '0; // RL4 RL5
      next_state.tick = 1'b1; // RL4 RL5
    end else begin
      next_state.cnt = state.cnt + 1'b1; // RL3
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick_out = state.tick;

endmodule : act_tick_div

/* File: verilog/act_timing.sv */
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module act_timing
  import act_pkg::*;
(
  // Clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      sys_rst_in,
  // AXI4-Lite write address
  input  wire logic                      s_axi_awvalid_in,
  output logic                           s_axi_awready_out,
  input  wire logic [act_pkg::ACT_ADDR_W-1:0] s_axi_awaddr_in,
  // AXI4-Lite write data
  input  wire logic                      s_axi_wvalid_in,
  output logic                           s_axi_wready_out,
  input  wire logic [act_pkg::ACT_DATA_W-1:0] s_axi_wdata_in,
  input  wire logic [3:0]                s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic                           s_axi_bvalid_out,
  input  wire logic                      s_axi_bready_in,
  output logic [1:0]                     s_axi_bresp_out,
  // AXI4-Lite read address
  input  wire logic                      s_axi_arvalid_in,
  output logic                           s_axi_arready_out,
  input  wire logic [act_pkg::ACT_ADDR_W-1:0] s_axi_araddr_in,
  // AXI4-Lite read data
  output logic                           s_axi_rvalid_out,
  input  wire logic                      s_axi_rready_in,
  output logic [act_pkg::ACT_DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0]                     s_axi_rresp_out,
  // Clock sources and sampling
  input  wire logic                      rc_clk_tick_in,
  input  wire logic                      sample_start_in,
  output logic                           conv_clock_tick_out,
  output logic                           conv_clock_source_sel_out,
  output logic [act_pkg::ACT_SAMC_W-1:0] auto_sample_time_out,
  output logic [act_pkg::ACT_DIV_W-1:0]  conv_clock_divider_out,
  output logic                           sampling_out,
  output logic                           sample_done_out
);

  import act_pkg::*;

  typedef struct packed {
    logic [ACT_REG_W-1:0]  ctrl;
    logic                  aw_got;
    logic [ACT_ADDR_W-1:0] awaddr;
    logic                  w_got;
    logic [ACT_DATA_W-1:0] wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [ACT_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
    logic                  sampling;
    logic [ACT_SAMC_W-1:0] samp_cnt;
    logic                  samp_done;
    logic                  conv_tick;
  } act_state_t;

  act_state_t state;
  act_state_t next_state;

  logic                  sys_tick;
  logic                  div_restart;
  logic                  src_sel;
  logic [ACT_SAMC_W-1:0] samc;
  logic [ACT_DIV_W-1:0]  div;
  logic [ACT_REG_W-1:0]  wr_mask;
  logic [ACT_REG_W-1:0]  stat_word;
  logic                  aw_hs;
  logic                  w_hs;
  logic                  ar_hs;

  assign src_sel = state.ctrl[ACT_SRC_BIT];
  assign samc    = state.ctrl[ACT_SAMC_LSB +: ACT_SAMC_W];
  assign div     = state.ctrl[ACT_DIV_LSB +: ACT_DIV_W];

  // Counter restarts when any control bit changes, and is held in restart while the RC source is selected
  assign div_restart = src_sel | (next_state.ctrl != state.ctrl);

  act_tick_div #(
    .DIV_W      (ACT_DIV_W)
  ) u_div (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .div_in     (div),
    .restart_in (div_restart),
    .tick_out   (sys_tick)
  );

  assign s_axi_awready_out = ~state.aw_got & ~state.bvalid;
  assign s_axi_wready_out  = ~state.w_got & ~state.bvalid;
  assign s_axi_arready_out = ~state.rvalid;
  assign aw_hs = s_axi_awvalid_in & s_axi_awready_out;
  assign w_hs  = s_axi_wvalid_in & s_axi_wready_out;
  assign ar_hs = s_axi_arvalid_in & s_axi_arready_out;

  always_comb begin
    wr_mask = ACT_CTRL_WMASK; // RL6
    if (!state.wstrb[ACT_LANE_LO]) begin
      wr_mask = wr_mask & ~ACT_LANE_LO_MSK;
    end
    if (!state.wstrb[ACT_LANE_HI]) begin
      wr_mask = wr_mask & ~ACT_LANE_HI_MSK;
    end
  end

  always_comb begin
    stat_word = '0;
    stat_word[ACT_STAT_SRC_BIT]                   = src_sel;
    stat_word[ACT_STAT_BUSY_BIT]                  = state.sampling;
    stat_word[ACT_STAT_CNT_LSB +: ACT_SAMC_W]     = state.samp_cnt;
  end

  always_comb begin
    next_state = state;
    next_state.samp_done = 1'b0;

    // Write channel: address and data in either order
    if (aw_hs) begin
      next_state.aw_got = 1'b1;
      next_state.awaddr = s_axi_awaddr_in;
    end
    if (w_hs) begin
      next_state.w_got = 1'b1;
      next_state.wdata = s_axi_wdata_in;
      next_state.wstrb = s_axi_wstrb_in;
    end
    if (state.aw_got && state.w_got) begin
      next_state.aw_got = 1'b0;
      next_state.w_got  = 1'b0;
      next_state.bvalid = 1'b1;
      if (state.awaddr == ACT_CTRL_OFFSET) begin
        next_state.ctrl  = (state.ctrl & ~wr_mask)
                         | (state.wdata[ACT_REG_W-1:0] & wr_mask); // RL6
        next_state.bresp = ACT_RESP_OKAY;
      end else if (state.awaddr == ACT_STAT_OFFSET) begin
        next_state.bresp = ACT_RESP_OKAY;
      end else begin
        next_state.bresp = ACT_RESP_SLVERR;
      end
    end
    if (state.bvalid && s_axi_bready_in) begin
      next_state.bvalid = 1'b0;
    end

    // Read channel
    if (ar_hs) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = ACT_RESP_OKAY;
      if (s_axi_araddr_in == ACT_CTRL_OFFSET) begin
        next_state.rdata = {{(ACT_DATA_W-ACT_REG_W){1'b0}},
                            state.ctrl & ACT_CTRL_WMASK}; // RL6
      end else if (s_axi_araddr_in == ACT_STAT_OFFSET) begin
        next_state.rdata = {{(ACT_DATA_W-ACT_REG_W){1'b0}}, stat_word};
      end else begin
        next_state.rdata = ACT_ZERO_WORD;
        next_state.rresp = ACT_RESP_SLVERR;
      end
    end else if (state.rvalid && s_axi_rready_in) begin
      next_state.rvalid = 1'b0;
    end

    // Conversion clock source
    if (src_sel) begin
      next_state.conv_tick = rc_clk_tick_in; // RL1
    end else begin
      next_state.conv_tick = sys_tick; // RL1 RL4
    end

    // Auto-sample window counted in conversion clock periods
    if (!state.sampling) begin
      if (sample_start_in) begin
        if (samc == '0) begin
          next_state.samp_done = 1'b1;
        end else begin
          next_state.sampling = 1'b1;
          next_state.samp_cnt = samc; // RL2
        end
      end
    end else if (state.conv_tick) begin
      next_state.samp_cnt = state.samp_cnt - 1'b1; // RL2
      if (state.samp_cnt == {{(ACT_SAMC_W-1){1'b0}}, 1'b1}) begin
        next_state.sampling  = 1'b0;
        next_state.samp_done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state      <= '0;
      state.ctrl <= ACT_CTRL_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_bvalid_out          = state.bvalid;
  assign s_axi_bresp_out           = state.bresp;
  assign s_axi_rvalid_out          = state.rvalid;
  assign s_axi_rdata_out           = state.rdata;
  assign s_axi_rresp_out           = state.rresp;
  assign conv_clock_tick_out       = state.conv_tick;
  assign conv_clock_source_sel_out = src_sel;
  assign auto_sample_time_out      = samc;
  assign conv_clock_divider_out    = div;
  assign sampling_out              = state.sampling;
  assign sample_done_out           = state.samp_done;

endmodule : act_timing
